/* mts_pkg.sv */
package mts_pkg;

  // register offsets
  localparam logic [7:0] MTS_ADDR_CONFIG   = 8'h25;
  localparam logic [7:0] MTS_ADDR_CONTROL  = 8'h26;
  localparam logic [7:0] MTS_ADDR_LINE_UP  = 8'h27;
  localparam logic [7:0] MTS_ADDR_LINE_LO  = 8'h28;
  localparam logic [7:0] MTS_ADDR_STATUS   = 8'h29;
  localparam logic [7:0] MTS_ADDR_P0_UP    = 8'h2a;
  localparam logic [7:0] MTS_ADDR_P0_LO    = 8'h2b;
  localparam logic [7:0] MTS_ADDR_P3_LO    = 8'h31;

  // reset values
  localparam logic [7:0] MTS_RST_CONFIG    = 8'h00;
  localparam logic [7:0] MTS_RST_CONTROL   = 8'h00;
  localparam logic [7:0] MTS_RST_LINE      = 8'h00;

  // writable-bit masks; reserved bits read zero
  localparam logic [7:0] MTS_MASK_CONFIG   = 8'h7b;
  localparam logic [7:0] MTS_MASK_CONTROL  = 8'h1f;

  // configuration field positions
  localparam int MTS_CFG_EDGE_BIT          = 6;
  localparam int MTS_CFG_RES_HI            = 5;
  localparam int MTS_CFG_RES_LO            = 4;
  localparam int MTS_CFG_EARLY_BIT         = 3;
  localparam int MTS_CFG_FREE_BIT          = 1;
  localparam int MTS_CFG_POINT_BIT         = 0;

  // control field positions
  localparam int MTS_CTL_HOLD_BIT          = 4;

  // status layout
  localparam int MTS_STS_READY_BIT         = 4;

  localparam int MTS_PORTS                 = 4;
  localparam int MTS_STAMP_W               = 16;
  localparam int MTS_BYTE_W                = 8;

  // resolution steps in ns and the core clock period
  localparam int MTS_CLK_PERIOD_NS         = 10;
  localparam int MTS_RES0_NS               = 40;
  localparam int MTS_RES1_NS               = 80;
  localparam int MTS_RES2_NS               = 160;
  localparam int MTS_RES3_NS               = 1000;
  localparam int MTS_DIV_W                 = 7;
  localparam logic [MTS_DIV_W-1:0] MTS_RES0_CYC = MTS_DIV_W'(MTS_RES0_NS / MTS_CLK_PERIOD_NS);
  localparam logic [MTS_DIV_W-1:0] MTS_RES1_CYC = MTS_DIV_W'(MTS_RES1_NS / MTS_CLK_PERIOD_NS);
  localparam logic [MTS_DIV_W-1:0] MTS_RES2_CYC = MTS_DIV_W'(MTS_RES2_NS / MTS_CLK_PERIOD_NS);
  localparam logic [MTS_DIV_W-1:0] MTS_RES3_CYC = MTS_DIV_W'(MTS_RES3_NS / MTS_CLK_PERIOD_NS);

  localparam logic [1:0] MTS_RES_40        = 2'h0;
  localparam logic [1:0] MTS_RES_80        = 2'h1;
  localparam logic [1:0] MTS_RES_160       = 2'h2;

endpackage

/* mts_port_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module mts_port_capture
  import mts_pkg::*;
(
  input  wire logic                   clk_sys_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   enable_in,
  input  wire logic                   hold_in,
  input  wire logic                   frame_point_in,
  input  wire logic                   free_run_in,
  input  wire logic [MTS_STAMP_W-1:0] line_num_in,
  input  wire logic                   round_start_in,
  input  wire logic                   frame_start_in,
  input  wire logic                   line_start_in,
  input  wire logic [MTS_STAMP_W-1:0] stamp_in,
  output logic      [MTS_STAMP_W-1:0] stamp_out,
  output logic                        valid_out
);

  logic [MTS_STAMP_W-1:0] line_cnt_reg;
  logic [MTS_STAMP_W-1:0] line_cnt_next;
  logic                   armed_reg;
  logic                   look_reg;
  logic                   line_hit;
  logic                   capture;

  // lines are numbered from one: first line start after frame start is line 1
  assign line_cnt_next = line_cnt_reg + MTS_STAMP_W'(1);
  assign line_hit      = line_start_in && !frame_start_in && (line_cnt_next == line_num_in);

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      line_cnt_reg <= '0;
    else if (frame_start_in)
      line_cnt_reg <= '0;
    else if (line_start_in)
      line_cnt_reg <= line_cnt_next;
  end

  // in frame-sync mode one capture per active sync edge; free-run always armed
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      armed_reg <= 1'b0;
    else if (round_start_in)
      armed_reg <= 1'b1;
    else if (capture)
      armed_reg <= 1'b0;
  end

  // free-run frame mode: watch for frame start only after the programmed line
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      look_reg <= 1'b0;
    else if (line_hit)
      look_reg <= 1'b1;
    else if (frame_start_in)
      look_reg <= 1'b0;
  end

  always_comb
  begin
    capture = 1'b0;
    if (enable_in && !hold_in)
    begin
      if (free_run_in)
        capture = frame_point_in ? (frame_start_in && look_reg) : line_hit;
      else if (armed_reg)
        capture = frame_point_in ? frame_start_in : line_hit;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      stamp_out <= '0;
    else if (capture)
      stamp_out <= stamp_in;
  end

  // a capture in the same cycle as a new round keeps the flag set
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      valid_out <= 1'b0;
    else if (capture)
      valid_out <= 1'b1;
    else if (round_start_in && !hold_in)
      valid_out <= 1'b0;
  end

endmodule
`default_nettype wire

/* mts_timestamp_capture.sv */
// What this block does
// - sync edge select picks rising or falling
// - two-bit field sets count resolution
// - early ready: ready once all available
// - free-run bit ignores frame-sync input
// - capture at programmed line or frame start
// - hold freezes results, setting clears ready
// - per-port enable bits gate capture
// - 16-bit line number from two bytes
// - free-run frame mode waits for line
// - ready flag in status bit four
// - per-port valid flags in status bits
// - upper result byte per port
// - lower result byte per port
`timescale 1ns/1ps
`default_nettype none
module mts_timestamp_capture
  import mts_pkg::*;
(
  input  wire logic                   clk_sys_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   frame_sync_in,
  input  wire logic [MTS_PORTS-1:0]   port_frame_start_in,
  input  wire logic [MTS_PORTS-1:0]   port_line_start_in,
  input  wire logic [7:0]             reg_addr_in,
  input  wire logic [MTS_BYTE_W-1:0]  reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [MTS_BYTE_W-1:0]  reg_rdata_out,
  output logic                        reg_rvalid_out
);

  logic [MTS_BYTE_W-1:0]  config_reg;
  logic [MTS_BYTE_W-1:0]  control_reg;
  logic [MTS_BYTE_W-1:0]  line_upper_reg;
  logic [MTS_BYTE_W-1:0]  line_lower_reg;
  logic                   ready_reg;
  logic [2:0]             sync_pipe_reg;
  logic                   sync_level_reg;
  logic [MTS_DIV_W-1:0]   div_cnt_reg;
  logic [MTS_STAMP_W-1:0] stamp_reg;

  logic                   sync_edge_select;
  logic [1:0]             count_resolution_select;
  logic                   early_ready_select;
  logic                   free_run_select;
  logic                   capture_point_select;
  logic                   hold_results;
  logic [MTS_PORTS-1:0]   port_capture_enable;
  logic [MTS_STAMP_W-1:0] capture_line;
  logic                   sync_change;
  logic                   sync_active;
  logic                   tick;
  logic                   wrap;
  logic                   round_start;
  logic                   hold_set;
  logic                   all_valid;
  logic [MTS_PORTS-1:0]   port_result_valid;
  logic [MTS_STAMP_W-1:0] port_result [MTS_PORTS];

  // ------------------------------------------------------------------
  // field views
  // ------------------------------------------------------------------
  assign sync_edge_select        = config_reg[MTS_CFG_EDGE_BIT];
  assign count_resolution_select = config_reg[MTS_CFG_RES_HI:MTS_CFG_RES_LO];
  assign early_ready_select      = config_reg[MTS_CFG_EARLY_BIT];
  assign free_run_select         = config_reg[MTS_CFG_FREE_BIT];
  assign capture_point_select    = config_reg[MTS_CFG_POINT_BIT];
  assign hold_results            = control_reg[MTS_CTL_HOLD_BIT];
  assign port_capture_enable     = control_reg[MTS_PORTS-1:0];
  assign capture_line            = {line_upper_reg, line_lower_reg};

  function automatic logic [MTS_DIV_W-1:0] res_cycles(input logic [1:0] sel);
    logic [MTS_DIV_W-1:0] cyc;
    unique case (sel)
      MTS_RES_40:  cyc = MTS_RES0_CYC;
      MTS_RES_80:  cyc = MTS_RES1_CYC;
      MTS_RES_160: cyc = MTS_RES2_CYC;
      default:     cyc = MTS_RES3_CYC;
    endcase
    return cyc;
  endfunction

  function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      config_reg <= MTS_RST_CONFIG;
    else if (reg_wr_in && hits(reg_addr_in, MTS_ADDR_CONFIG))
      config_reg <= reg_wdata_in & MTS_MASK_CONFIG;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      control_reg <= MTS_RST_CONTROL;
    else if (reg_wr_in && hits(reg_addr_in, MTS_ADDR_CONTROL))
      control_reg <= reg_wdata_in & MTS_MASK_CONTROL;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      line_upper_reg <= MTS_RST_LINE;
    else if (reg_wr_in && hits(reg_addr_in, MTS_ADDR_LINE_UP))
      line_upper_reg <= reg_wdata_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      line_lower_reg <= MTS_RST_LINE;
    else if (reg_wr_in && hits(reg_addr_in, MTS_ADDR_LINE_LO))
      line_lower_reg <= reg_wdata_in;
  end

  // a write that turns the hold on, seen before the control register updates
  assign hold_set = reg_wr_in && hits(reg_addr_in, MTS_ADDR_CONTROL)
                    && reg_wdata_in[MTS_CTL_HOLD_BIT] && !hold_results;

  // ------------------------------------------------------------------
  // frame-sync input: three flops, change accepted when stages 2 and 3 agree
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      sync_pipe_reg <= '0;
    else
      sync_pipe_reg <= {sync_pipe_reg[1:0], frame_sync_in};
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      sync_level_reg <= 1'b0;
    else if (sync_pipe_reg[1] == sync_pipe_reg[2])
      sync_level_reg <= sync_pipe_reg[2];
  end

  assign sync_change = (sync_pipe_reg[1] == sync_pipe_reg[2]) && (sync_pipe_reg[2] != sync_level_reg);
  // polarity 0 keeps the rising edge, 1 the falling edge
  assign sync_active = sync_change && (sync_pipe_reg[2] != sync_edge_select);

  // ------------------------------------------------------------------
  // timestamp counter
  // ------------------------------------------------------------------
  // prescaler restarts with the counter so the first step after a sync edge is a full step
  assign tick = (div_cnt_reg >= res_cycles(count_resolution_select) - MTS_DIV_W'(1));

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      div_cnt_reg <= '0;
    else if ((sync_active && !free_run_select) || tick)
      div_cnt_reg <= '0;
    else
      div_cnt_reg <= div_cnt_reg + MTS_DIV_W'(1);
  end

  assign wrap = tick && (stamp_reg == '1);

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      stamp_reg <= '0;
    else if (sync_active && !free_run_select)
      stamp_reg <= '0;
    else if (tick)
      stamp_reg <= stamp_reg + MTS_STAMP_W'(1);
  end

  // a round opens at each active sync edge, or at each counter wrap in free-run
  assign round_start = free_run_select ? wrap : sync_active;

  // ------------------------------------------------------------------
  // per-port capture
  // ------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < MTS_PORTS; p++)
    begin : g_port
      mts_port_capture u_port (
        .clk_sys_in     (clk_sys_in),
        .sys_rst_in     (sys_rst_in),
        .enable_in      (port_capture_enable[p]),
        .hold_in        (hold_results),
        .frame_point_in (capture_point_select),
        .free_run_in    (free_run_select),
        .line_num_in    (capture_line),
        .round_start_in (round_start),
        .frame_start_in (port_frame_start_in[p]),
        .line_start_in  (port_line_start_in[p]),
        .stamp_in       (stamp_reg),
        .stamp_out      (port_result[p]),
        .valid_out      (port_result_valid[p])
      );
    end
  endgenerate

  // disabled ports do not hold ready back; no enabled port means never ready
  assign all_valid = (&(port_result_valid | ~port_capture_enable)) && (|port_capture_enable);

  // ------------------------------------------------------------------
  // ready flag
  // ------------------------------------------------------------------
  // setting the hold wins over any set in the same cycle, as the hold is meant to clear it
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      ready_reg <= 1'b0;
    else if (hold_set)
      ready_reg <= 1'b0;
    else if (hold_results)
      ready_reg <= ready_reg;
    else if (round_start)
      ready_reg <= !early_ready_select && all_valid;
    else if (early_ready_select && all_valid)
      ready_reg <= 1'b1;
  end

  // ------------------------------------------------------------------
  // register reads, answered one cycle after the strobe
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= '0;
    else if (reg_rd_in)
    begin
      reg_rdata_out <= '0;
      if (hits(reg_addr_in, MTS_ADDR_CONFIG))
        reg_rdata_out <= config_reg;
      else if (hits(reg_addr_in, MTS_ADDR_CONTROL))
        reg_rdata_out <= control_reg;
      else if (hits(reg_addr_in, MTS_ADDR_LINE_UP))
        reg_rdata_out <= line_upper_reg;
      else if (hits(reg_addr_in, MTS_ADDR_LINE_LO))
        reg_rdata_out <= line_lower_reg;
      else if (hits(reg_addr_in, MTS_ADDR_STATUS))
      begin
        reg_rdata_out[MTS_STS_READY_BIT] <= ready_reg;
        reg_rdata_out[MTS_PORTS-1:0]     <= port_result_valid;
      end
      else if (reg_addr_in >= MTS_ADDR_P0_UP && reg_addr_in <= MTS_ADDR_P3_LO)
      begin
        // two bytes per port, upper byte at the even offset
        if (reg_addr_in[0] == MTS_ADDR_P0_UP[0])
          reg_rdata_out <= port_result[2'((reg_addr_in - MTS_ADDR_P0_UP) >> 1)]
                             [MTS_STAMP_W-1:MTS_BYTE_W];
        else
          reg_rdata_out <= port_result[2'((reg_addr_in - MTS_ADDR_P0_UP) >> 1)]
                             [MTS_BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      reg_rvalid_out <= 1'b0;
    else
      reg_rvalid_out <= reg_rd_in;
  end

endmodule
`default_nettype wire

/* mts_timestamp_capture_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module mts_timestamp_capture_sva
  import mts_pkg::*;
(
  input wire logic                  clk_sys_in,
  input wire logic                  sys_rst_in,
  input wire logic                  frame_sync_in,
  input wire logic [MTS_PORTS-1:0]  port_frame_start_in,
  input wire logic [MTS_PORTS-1:0]  port_line_start_in,
  input wire logic [7:0]            reg_addr_in,
  input wire logic [MTS_BYTE_W-1:0] reg_wdata_in,
  input wire logic                  reg_wr_in,
  input wire logic                  reg_rd_in,
  input wire logic [MTS_BYTE_W-1:0] reg_rdata_out,
  input wire logic                  reg_rvalid_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_rd(logic [7:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence

  property p_rv_follow;
    reg_rd_in |=> reg_rvalid_out;
  endproperty
  a_rv_follow: assert property (p_rv_follow) else $error("read not answered next cycle");

  property p_rv_cause;
    reg_rvalid_out |-> $past(reg_rd_in);
  endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("read answer without read");

  property p_rdata_hold;
    !reg_rvalid_out |-> $stable(reg_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between reads");

  property p_sts_rsvd;
    s_rd(MTS_ADDR_STATUS) |=> reg_rdata_out[7:5] == 3'h0;
  endproperty
  a_sts_rsvd: assert property (p_sts_rsvd) else $error("status spare bits set");

  property p_cfg_rsvd;
    s_rd(MTS_ADDR_CONFIG) |=> !reg_rdata_out[7] && !reg_rdata_out[2];
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config spare bits set");

  property p_ctl_rsvd;
    s_rd(MTS_ADDR_CONTROL) |=> reg_rdata_out[7:5] == 3'h0;
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control spare bits set");

  property p_unmapped;
    reg_rd_in && (reg_addr_in < MTS_ADDR_CONFIG || reg_addr_in > MTS_ADDR_P3_LO) |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_cfg_back;
    logic [7:0] d;
    (reg_wr_in && reg_addr_in == MTS_ADDR_CONFIG, d = reg_wdata_in) ##1 !reg_wr_in
      ##1 (s_rd(MTS_ADDR_CONFIG) and !reg_wr_in) |=> reg_rdata_out == (d & MTS_MASK_CONFIG);
  endproperty
  a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");

  property p_hold_clr;
    (reg_wr_in && reg_addr_in == MTS_ADDR_CONTROL && reg_wdata_in[MTS_CTL_HOLD_BIT]) ##1 !reg_wr_in
      ##1 s_rd(MTS_ADDR_STATUS) |=> !reg_rdata_out[MTS_STS_READY_BIT];
  endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("ready seen while held");
endmodule

bind mts_timestamp_capture mts_timestamp_capture_sva chk_u (.clk_sys_in, .sys_rst_in, .frame_sync_in,
  .port_frame_start_in, .port_line_start_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .reg_rvalid_out);
`default_nettype wire

/* mts_timestamp_capture_test.sv */
`timescale 1ns/1ps
`default_nettype none
module mts_timestamp_capture_test;
  import mts_pkg::*;
  logic                  clk;
  logic                  rst;
  logic                  fsync;
  logic [MTS_PORTS-1:0]  fs;
  logic [MTS_PORTS-1:0]  ls;
  logic [7:0]            addr;
  logic [MTS_BYTE_W-1:0] wdata;
  logic                  wr;
  logic                  rd;
  logic [MTS_BYTE_W-1:0] rdata;
  logic                  rvalid;
  int                    n_fail;
  int                    n_tests;

  mts_timestamp_capture dut_u (.clk_sys_in(clk), .sys_rst_in(rst), .frame_sync_in(fsync),
    .port_frame_start_in(fs), .port_line_start_in(ls), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid));
  mts_video_src vid_u (.clk_in(clk), .frame_start_out(fs), .line_start_out(ls));

  always #5 clk = ~clk;

  task automatic conclude;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr = 1;
    @(posedge clk);
    #1 wr = 0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    rd = 1;
    @(posedge clk);
    #1 rd = 0;
    check({15'h0, rvalid}, 16'h1);
    d = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rreg(a, d);
    check({8'h0, d}, {8'h0, e});
  endtask

  // counter phase is only pinned to a count or so, hence a window
  task automatic stamp(input int p, input int lo, input int hi);
    logic [7:0]  u;
    logic [7:0]  l;
    logic [15:0] v;
    rreg(MTS_ADDR_P0_UP + 8'(2 * p), u);
    rreg(MTS_ADDR_P0_LO + 8'(2 * p), l);
    v = {u, l};
    check({15'h0, v >= 16'(lo) && v <= 16'(hi)}, 16'h1);
  endtask

  task automatic reset_dut;
    fsync = 0;
    rst = 1;
    repeat (4) @(posedge clk);
    #1 rst = 0;
  endtask

  // sync pin moves, then a three-line frame starts gap cycles later
  task automatic run(input logic v, input int gap);
    @(posedge clk);
    #1 fsync = v;
    repeat (gap) @(posedge clk);
    vid_u.frame(3);
  endtask

  task automatic t_regs;
    reset_dut();
    for (int a = 8'h25; a <= 8'h31; a++) rchk(8'(a), 8'h00);
    wreg(MTS_ADDR_CONFIG, 8'hff);
    rchk(MTS_ADDR_CONFIG, 8'h7b);
    wreg(MTS_ADDR_CONTROL, 8'hef);
    rchk(MTS_ADDR_CONTROL, 8'h0f);
    wreg(MTS_ADDR_STATUS, 8'hff);
    rchk(MTS_ADDR_STATUS, 8'h00);
    wreg(MTS_ADDR_P0_UP, 8'hff);
    rchk(MTS_ADDR_P0_UP, 8'h00);
    wreg(MTS_ADDR_LINE_UP, 8'ha5);
    wreg(MTS_ADDR_LINE_LO, 8'h3c);
    rchk(MTS_ADDR_LINE_UP, 8'ha5);
    rchk(MTS_ADDR_LINE_LO, 8'h3c);
    rchk(8'h40, 8'h00);
  endtask

  // line 3 lands 125 cycles after the edge is seen: 31 counts of 4
  task automatic t_sync_line;
    reset_dut();
    wreg(MTS_ADDR_CONTROL, 8'h05);
    wreg(MTS_ADDR_LINE_LO, 8'h03);
    run(1'b1, 100);
    rchk(MTS_ADDR_STATUS, 8'h05);
    stamp(0, 30, 32);
    stamp(2, 30, 32);
    stamp(1, 0, 0);
    run(1'b0, 10);
    run(1'b1, 0);
    rchk(MTS_ADDR_STATUS, 8'h15);
  endtask

  task automatic t_early_hold;
    reset_dut();
    wreg(MTS_ADDR_CONFIG, 8'h68);
    wreg(MTS_ADDR_CONTROL, 8'h01);
    wreg(MTS_ADDR_LINE_LO, 8'h03);
    run(1'b1, 100);
    rchk(MTS_ADDR_STATUS, 8'h00);
    run(1'b0, 100);
    rchk(MTS_ADDR_STATUS, 8'h11);
    stamp(0, 6, 9);
    wreg(MTS_ADDR_CONTROL, 8'h11);
    rchk(MTS_ADDR_STATUS, 8'h01);
    run(1'b1, 10);
    run(1'b0, 200);
    rchk(MTS_ADDR_STATUS, 8'h01);
    stamp(0, 6, 9);
    wreg(MTS_ADDR_CONTROL, 8'h01);
    run(1'b1, 10);
    run(1'b0, 200);
    rchk(MTS_ADDR_STATUS, 8'h11);
    stamp(0, 13, 15);
  endtask

  task automatic t_free_frame;
    reset_dut();
    wreg(MTS_ADDR_CONFIG, 8'h03);
    wreg(MTS_ADDR_CONTROL, 8'h08);
    wreg(MTS_ADDR_LINE_LO, 8'h02);
    vid_u.frame(1);
    vid_u.frame(0);
    rchk(MTS_ADDR_STATUS, 8'h00);
    run(1'b1, 20);
    rchk(MTS_ADDR_STATUS, 8'h00);
    vid_u.frame(0);
    rchk(MTS_ADDR_STATUS, 8'h08);
    stamp(3, 1, 65535);
    run(1'b0, 20);
    rchk(MTS_ADDR_STATUS, 8'h08);
  endtask

  initial
  begin
    clk = 0;
    rst = 1;
    fsync = 0;
    addr = 0;
    wdata = 0;
    wr = 0;
    rd = 0;
    n_fail = 0;
    n_tests = 0;
    t_regs();
    t_sync_line();
    t_early_hold();
    t_free_frame();
    conclude();
  end

  // the whole run needs somewhat over a thousand cycles
  initial
  begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire

/* mts_video_src.sv */
`timescale 1ns/1ps
`default_nettype none
module mts_video_src
  import mts_pkg::*;
(
  input  wire logic                 clk_in,
  output logic      [MTS_PORTS-1:0] frame_start_out,
  output logic      [MTS_PORTS-1:0] line_start_out
);
  // all ports see one shared frame; no cross-port skew is modelled
  initial
  begin
    frame_start_out = '0;
    line_start_out  = '0;
  end

  // line pulses nine cycles apart so line timing is predictable
  task automatic frame(input int n_lines);
    @(posedge clk_in);
    #1 frame_start_out = '1;
    @(posedge clk_in);
    #1 frame_start_out = '0;
    repeat (n_lines)
    begin
      repeat (8) @(posedge clk_in);
      #1 line_start_out = '1;
      @(posedge clk_in);
      #1 line_start_out = '0;
    end
  endtask
endmodule
`default_nettype wire
